//--- aaas_pkg.sv
// Purpose: constants and types of the aux converter averaging/status block
// Assumes: 125 MHz system clock, 16-bit register words
// Notes:   result word i sits at AAAS_A_RES0 + i
package aaas_pkg;
   // ==========================================================
   // register addresses
   localparam logic [3:0] AAAS_A_CTRL = 4'h0;  // converter_control_low
   localparam logic [3:0] AAAS_A_STAT = 4'h1;  // converter_status
   localparam logic [3:0] AAAS_A_RES0 = 4'h5;  // first result word
   localparam int         AAAS_NCH    = 5;     // result channels
   // ==========================================================
   // control field positions
   localparam int AAAS_STOP_BIT = 14;          // write 1: stop, power down
   localparam int AAAS_SCAN_LSB = 10;          // scan_select
   localparam int AAAS_RES_LSB  = 8;           // resolution_sel
   localparam int AAAS_AVG_LSB  = 6;           // average_count_sel
   localparam int AAAS_CLK_LSB  = 4;           // conv_clock_sel
   localparam int AAAS_FILT_BIT = 0;           // filter_type_sel
   localparam logic [13:0] AAAS_CTRL_WMASK = 14'h3ff1;  // storable bits
   // ==========================================================
   // status field positions
   localparam int AAAS_CFG_LSB  = 14;          // conv_done_pin_cfg
   localparam int AAAS_HALT_BIT = 13;          // converter_halted_flag
   localparam int AAAS_PEND_BIT = 11;          // results_pending_flag
   // new-data flag bit per channel: battery1, battery2, aux, result_a, result_b
   localparam int AAAS_FLAG_BIT [AAAS_NCH] = '{6, 5, 4, 2, 1};
   // ==========================================================
   // reset values and codes
   localparam logic [1:0] AAAS_CFG_RST    = 2'b10;  // pin config after reset
   localparam logic [1:0] AAAS_CFG_DONE   = 2'b01;  // data-available mode
   localparam logic [3:0] AAAS_SCAN_PORT  = 4'b1011; // three-input port scan
   // ==========================================================
   // conversion clock periods (ns) and system cycles, rounded up
   localparam int AAAS_SYS_MHZ = 125;
   localparam int AAAS_T8M_NS  = 125;
   localparam int AAAS_T4M_NS  = 250;
   localparam int AAAS_T2M_NS  = 500;
   localparam int AAAS_T1M_NS  = 1000;
   localparam int AAAS_DIV_CYC [4] = '{
      (AAAS_T8M_NS * AAAS_SYS_MHZ + 999) / 1000,
      (AAAS_T4M_NS * AAAS_SYS_MHZ + 999) / 1000,
      (AAAS_T2M_NS * AAAS_SYS_MHZ + 999) / 1000,
      (AAAS_T1M_NS * AAAS_SYS_MHZ + 999) / 1000};
   localparam int AAAS_CONV_EXTRA = 4;         // periods beyond bit count
   // ==========================================================
   // types
   typedef enum logic [1:0] {
      AAAS_IDLE = 2'b00,
      AAAS_CONV = 2'b01,
      AAAS_FILT = 2'b11
   } aaas_state_type;

   typedef struct packed {
      aaas_state_type  st;      // engine state
      logic [13:0]     ctrl;    // stored control bits
      logic [1:0]      cfg;     // done pin config
      logic            halted;  // powered down
      logic            pend;    // results pending
      logic [4:0]      flags;   // per-channel new data
      logic [4:0][11:0] res;    // result words
      logic [14:0][11:0] samp;  // raw sample store
      logic [15:0]     sum;     // mean accumulator
      logic [4:0]      scnt;    // samples taken
      logic [3:0]      cand;    // median candidate
      logic [2:0]      chan;    // channel in progress
      logic [1:0]      step;    // position in port scan
      logic [6:0]      div;     // clock divider
      logic [4:0]      per;     // periods in conversion
      logic [11:0]     sync1;   // raw input, first stage
      logic [11:0]     sync2;   // raw input, second stage
      logic [15:0]     rdata;   // read data
      logic            done_n;  // done pin
      logic [2:0]      mux;     // channel select out
   } aaas_regs_type;
endpackage

//--- aaas_core.sv
// Purpose: averaging, conversion timing, done pin and status of aux converter
// Assumes: serial control port decoded upstream into rd/wr strobes
// Notes:   reads of result words clear their new-data flags
`timescale 1ns/1ps
module aaas_core
   import aaas_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   output logic      [15:0] reg_rdata,
   input  wire logic [11:0] adc_raw,
   output logic             conv_done_n,
   output logic      [2:0]  chan_sel
);
   // ==========================================================
   // state and decode signals
   aaas_regs_type s_reg;       // registered state
   aaas_regs_type s_next;      // next state
   logic          tick;        // one conversion clock period
   logic          set_end;     // result written this cycle
   logic          median_hit;  // candidate is the median
   logic [3:0]    nbits;       // resolution in bits
   logic [11:0]   rmask;       // resolution mask
   logic [4:0]    nsamp;       // samples per result
   logic [2:0]    shamt;       // mean divide shift
   logic [3:0]    kmed;        // median rank
   logic [6:0]    divlim;      // divider wrap value
   logic [11:0]   val;         // filtered value
   logic [2:0]    fchan;       // first channel of new scan
   logic          fvalid;      // scan code starts work
   logic [15:0]   stat;        // status word image
   logic [14:0]   lt_v;        // samples below candidate
   logic [14:0]   le_v;        // samples not above candidate
   logic          filt;        // median selected
   logic          scan_more;   // port scan continues

   assign filt = s_reg.ctrl[AAAS_FILT_BIT];

   // ==========================================================
   // median rank compare, one comparator pair per stored sample
   for (genvar j = 0; j < 15; j++) begin : g_cmp
      assign lt_v[j] = (5'(j) < s_reg.scnt) && (s_reg.samp[j] < s_reg.samp[s_reg.cand]);
      assign le_v[j] = (5'(j) < s_reg.scnt) && (s_reg.samp[j] <= s_reg.samp[s_reg.cand]);
   end

   // ==========================================================
   // next-state logic
   always_comb begin
      s_next    = s_reg;
      tick      = 1'b0;
      set_end   = 1'b0;
      scan_more = 1'b0;
      // resolution decode
      case (s_reg.ctrl[AAAS_RES_LSB+:2])
         2'b01: begin
            nbits = 4'd8;
            rmask = 12'hff0;
         end
         2'b10: begin
            nbits = 4'd10;
            rmask = 12'hffc;
         end
         default: begin
            nbits = 4'd12;
            rmask = 12'hfff;
         end
      endcase
      // sample count per averaging code and filter kind
      case (s_reg.ctrl[AAAS_AVG_LSB+:2])
         2'b01: begin
            nsamp = filt ? 5'd5 : 5'd4;
            shamt = 3'd2;
         end
         2'b10: begin
            nsamp = filt ? 5'd9 : 5'd8;
            shamt = 3'd3;
         end
         2'b11: begin
            nsamp = filt ? 5'd15 : 5'd16;
            shamt = 3'd4;
         end
         default: begin
            nsamp = 5'd1;
            shamt = 3'd0;
         end
      endcase
      // odd counts only reach the median path, so n/2 is the middle rank
      kmed       = nsamp[4:1];
      median_hit = (5'($countones(lt_v)) <= {1'b0, kmed})
                   && (5'($countones(le_v)) > {1'b0, kmed});
      val        = filt ? s_reg.samp[s_reg.cand] : 12'(s_reg.sum >> shamt);
      divlim     = 7'(AAAS_DIV_CYC[s_reg.ctrl[AAAS_CLK_LSB+:2]] - 1);
      // first channel for a newly written scan code
      fvalid = 1'b1;
      case (reg_wdata[AAAS_SCAN_LSB+:4])
         4'b0110: fchan = 3'd0;
         4'b0111: fchan = 3'd1;
         4'b1000: fchan = 3'd2;
         4'b1001: fchan = 3'd2;
         4'b1010: fchan = 3'd3;
         4'b1011: fchan = 3'd0;
         4'b1100: fchan = 3'd4;
         default: begin
            fchan  = 3'd0;
            fvalid = 1'b0;
         end
      endcase
      // status word, reserved positions stay zero
      stat = 16'h0000;
      stat[AAAS_CFG_LSB+:2] = s_reg.cfg;
      stat[AAAS_HALT_BIT]   = s_reg.halted;
      stat[AAAS_PEND_BIT]   = s_reg.pend;
      for (int i = 0; i < AAAS_NCH; i++) begin
         stat[AAAS_FLAG_BIT[i]] = s_reg.flags[i];
      end

      // reading a result word clears its flag; sets below win
      if (reg_rd && reg_addr >= AAAS_A_RES0 && reg_addr < AAAS_A_RES0 + 4'd5) begin
         s_next.flags[3'(reg_addr - AAAS_A_RES0)] = 1'b0;
      end
      if (s_next.flags == 5'h00) begin
         s_next.pend = 1'b0;
      end

      // conversion engine
      case (s_reg.st)
         AAAS_CONV: begin
            // divider gives one enable per conversion clock period
            if (s_reg.div >= divlim) begin
               s_next.div = 7'd0;
               tick       = 1'b1;
            end else begin
               s_next.div = s_reg.div + 7'd1;
            end
            if (tick) begin
               if (s_reg.per == 5'(nbits) + 5'd3) begin
                  s_next.per = 5'd0;
                  if (s_reg.scnt < 5'd15) begin
                     s_next.samp[s_reg.scnt[3:0]] = s_reg.sync2 & rmask;
                  end
                  s_next.sum  = s_reg.sum + 16'(s_reg.sync2 & rmask);
                  s_next.scnt = s_reg.scnt + 5'd1;
                  if (s_reg.scnt + 5'd1 == nsamp) begin
                     s_next.st   = AAAS_FILT;
                     s_next.cand = 4'd0;
                  end
               end else begin
                  s_next.per = s_reg.per + 5'd1;
               end
            end
         end
         AAAS_FILT: begin
            // mean ends at once; median walks candidates until rank fits
            if (!filt || median_hit) begin
               set_end                = 1'b1;
               s_next.res[s_reg.chan]  = val;
               s_next.flags[s_reg.chan] = 1'b1;
               scan_more = (s_reg.ctrl[AAAS_SCAN_LSB+:4] == AAAS_SCAN_PORT)
                           && (s_reg.step != 2'd2);
               if (scan_more) begin
                  s_next.step = s_reg.step + 2'd1;
                  s_next.chan = s_reg.chan + 3'd1;
                  s_next.scnt = 5'd0;
                  s_next.sum  = 16'h0000;
                  s_next.per  = 5'd0;
                  s_next.div  = 7'd0;
                  s_next.st   = AAAS_CONV;
               end else begin
                  s_next.pend = 1'b1;
                  s_next.st   = AAAS_IDLE;
               end
            end else begin
               s_next.cand = s_reg.cand + 4'd1;
            end
         end
         default: begin
            s_next.st = AAAS_IDLE;
         end
      endcase

      // control write: stop wins, else a valid code restarts the engine
      if (reg_wr && reg_addr == AAAS_A_CTRL) begin
         s_next.ctrl = reg_wdata[13:0] & AAAS_CTRL_WMASK;
         s_next.st   = AAAS_IDLE;
         if (reg_wdata[AAAS_STOP_BIT]) begin
            s_next.halted = 1'b1;
         end else if (fvalid) begin
            s_next.chan   = fchan;
            s_next.step   = 2'd0;
            s_next.scnt   = 5'd0;
            s_next.sum    = 16'h0000;
            s_next.div    = 7'd0;
            s_next.per    = 5'd0;
            s_next.st     = AAAS_CONV;
            s_next.halted = 1'b0;
         end
      end
      // only the pin config is writable in the status word
      if (reg_wr && reg_addr == AAAS_A_STAT) begin
         s_next.cfg = reg_wdata[AAAS_CFG_LSB+:2];
      end

      // read data mux
      if (reg_rd) begin
         if (reg_addr == AAAS_A_CTRL) begin
            // busy bit reads inverted; clock field returns its encoding
            s_next.rdata = {1'b0, s_reg.st == AAAS_IDLE, s_reg.ctrl[13:4], 3'b000,
                            s_reg.ctrl[0]};
         end else if (reg_addr == AAAS_A_STAT) begin
            s_next.rdata = stat;
         end else if (reg_addr >= AAAS_A_RES0 && reg_addr < AAAS_A_RES0 + 4'd5) begin
            s_next.rdata = {4'h0, s_reg.res[3'(reg_addr - AAAS_A_RES0)]};
         end else begin
            s_next.rdata = 16'h0000;
         end
      end

      // pin low while pending and configured; other codes keep it high
      s_next.done_n = !(s_next.cfg == AAAS_CFG_DONE && s_next.pend);
      s_next.mux    = s_next.chan;
      // raw input crosses in through two flops
      s_next.sync1  = adc_raw;
      s_next.sync2  = s_reg.sync1;
   end

   // ==========================================================
   // state register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_reg        <= '0;
         s_reg.cfg    <= AAAS_CFG_RST;
         s_reg.done_n <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign reg_rdata   = s_reg.rdata;
   assign conv_done_n = s_reg.done_n;
   assign chan_sel    = s_reg.mux;

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_ctrl_wr;
      reg_wr && reg_addr == AAAS_A_CTRL;
   endsequence
   sequence s_ctrl_rd;
      reg_rd && !reg_wr && reg_addr == AAAS_A_CTRL;
   endsequence
   sequence s_set_idle;
      (set_end && !reg_wr) ##1 (s_reg.st == AAAS_IDLE);
   endsequence

   a_clk_readback: assert property (s_ctrl_wr
      ##1 !(reg_wr && reg_addr == AAAS_A_CTRL) ##1 s_ctrl_rd
      |=> reg_rdata[5:4] == $past(reg_wdata[5:4], 3))
      else $error("clock field read back wrong");
   a_div_range: assert property (s_reg.st == AAAS_CONV |-> s_reg.div <= divlim)
      else $error("divider past its period");
   a_conv_len: assert property (s_reg.st == AAAS_CONV
      |-> s_reg.per <= 5'(nbits) + 5'd3)
      else $error("conversion longer than bits plus four");
   a_samp_count: assert property (s_reg.st == AAAS_FILT |-> s_reg.scnt == nsamp)
      else $error("wrong sample count before filtering");
   a_mean_fast: assert property ((s_reg.st == AAAS_FILT && !filt) |-> set_end)
      else $error("mean filter did not finish");
   a_pend_set: assert property (s_set_idle |-> s_reg.pend)
      else $error("pending flag not set after set");
   a_pin_low: assert property (s_set_idle ##0 (s_reg.cfg == AAAS_CFG_DONE)
      |-> !conv_done_n)
      else $error("done pin not low after set");
   // reading the last unread word may release the pin, so that case is left out
   a_pin_hold: assert property ((!conv_done_n && |s_reg.flags && !reg_wr
      && !(reg_rd && $onehot(s_reg.flags))) |=> !conv_done_n)
      else $error("done pin released with unread results");
   a_flag_clear: assert property ((reg_rd && reg_addr == AAAS_A_RES0
      && s_reg.st == AAAS_IDLE) |=> !s_reg.flags[0])
      else $error("battery flag not cleared by read");
   a_temp_clear: assert property ((reg_rd && reg_addr == AAAS_A_RES0 + 4'd3
      && s_reg.st == AAAS_IDLE) |=> !s_reg.flags[3])
      else $error("temperature flag not cleared by read");
   a_halt_stop: assert property ((s_ctrl_wr and reg_wdata[AAAS_STOP_BIT])
      |=> s_reg.halted && s_reg.st == AAAS_IDLE)
      else $error("stop did not halt converter");
   a_rsvd_zero: assert property ((reg_rd && reg_addr == AAAS_A_STAT)
      |=> reg_rdata[12] == 1'b0 && reg_rdata[10:7] == 4'h0
          && reg_rdata[3] == 1'b0 && reg_rdata[0] == 1'b0)
      else $error("reserved status bits not zero");
endmodule

//--- aaas_host.sv
// Purpose: host model that drives the register port of the aux converter block
// Assumes: strobes launched 1 ns after the rising edge, one word per access
// Notes:   released write data is inverted so that no stale word lingers
`timescale 1ns/1ps
module aaas_host
   import aaas_pkg::*;
(
   input  wire logic        sys_clk,
   output logic             reg_wr,
   output logic             reg_rd,
   output logic      [3:0]  reg_addr,
   output logic      [15:0] reg_wdata,
   input  wire logic [15:0] reg_rdata
);
   // ==========================================================
   // idle bus at time zero
   initial begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 4'h0;
      reg_wdata = 16'h0000;
   end

   // one write, strobe held across the edge that takes it
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      #1;
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_wr    = 1'b0;
      reg_wdata = ~d;  // data no longer qualified
   endtask

   // one read, word taken one cycle after the strobe edge
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_rd   = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_rd   = 1'b0;
      @(posedge sys_clk);
      #1;
      d = reg_rdata;
   endtask

   // done pin set to data-available mode before any conversion
   task automatic set_cfg;
      wr(AAAS_A_STAT, {AAAS_CFG_DONE, 14'h0000});
   endtask
endmodule

//--- aux_adc_average_status_tb.sv
// Purpose: self-checking bench of the aux converter averaging/status block
// Assumes: adc_raw held steady per case, so mean and median give the raw code
// Notes:   raw codes chosen so the resolution mask of each case leaves them unchanged
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module aux_adc_average_status_tb;
   import aaas_pkg::*;
   typedef struct {
      logic [3:0]  scan;
      logic [1:0]  res;
      logic [1:0]  avg;
      logic [1:0]  clk;
      logic        filt;
      int          ch;
      logic [11:0] raw;
      int          n;
      int          bits;
   } aaas_row_type;
   // ==========================================================
   // case table: clock code only with resolutions it allows
   aaas_row_type rows [8] = '{
      '{4'b0110, 2'b01, 2'b11, 2'b00, 1'b0, 0, 12'h0F0, 16, 8},
      '{4'b0111, 2'b10, 2'b10, 2'b01, 1'b1, 1, 12'h250, 9, 10},
      '{4'b1000, 2'b00, 2'b01, 2'b10, 1'b0, 2, 12'hA5C, 4, 12},
      '{4'b1010, 2'b11, 2'b00, 2'b11, 1'b1, 3, 12'h5A3, 1, 12},
      '{4'b1100, 2'b01, 2'b01, 2'b00, 1'b1, 4, 12'h0F0, 5, 8},
      '{4'b1001, 2'b10, 2'b11, 2'b01, 1'b1, 2, 12'h250, 15, 10},
      '{4'b0110, 2'b01, 2'b10, 2'b00, 1'b0, 0, 12'h0F0, 8, 8},
      '{4'b0111, 2'b01, 2'b00, 2'b00, 1'b0, 1, 12'h0F0, 1, 8}};
   logic              sys_clk;      // system clock
   logic              rst;          // sync reset
   logic              reg_wr;       // write strobe
   logic              reg_rd;       // read strobe
   logic       [3:0]  reg_addr;     // word address
   logic       [15:0] reg_wdata;    // write word
   logic       [15:0] reg_rdata;    // read word
   logic       [11:0] adc_raw;      // raw code
   logic              conv_done_n;  // done pin
   logic       [2:0]  chan_sel;     // channel in progress
   logic       [15:0] v;            // last word read
   logic       [15:0] w;            // control word written
   aaas_row_type      r;            // current case
   int                cnt;          // cycles until done pin low
   int                base;         // expected conversion cycles
   int                err_total = 0;
   int                compares  = 0;
   // ==========================================================
   // design, host model
   aaas_core dut (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .adc_raw(adc_raw), .conv_done_n(conv_done_n), .chan_sel(chan_sel));
   aaas_host host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   // verdict and end of run
   task automatic end_sim;
      if (err_total == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // start a set, then count cycles until the done pin falls
   task automatic run_set(input logic [15:0] cw, input int exp_cyc, input int ch);
      host.wr(AAAS_A_CTRL, cw);
      @(posedge sys_clk);
      #1;
      `CHK(chan_sel, 3'(ch))
      cnt = 1;
      while (conv_done_n !== 1'b0 && cnt < exp_cyc + 60) begin
         @(posedge sys_clk);
         #1;
         cnt++;
      end
   endtask
   // ==========================================================
   // 125 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // watchdog, well above the expected run of some 24k cycles
   initial begin
      #(100000 * 8);
      err_total++;
      end_sim;
   end
   // ==========================================================
   // main sequence
   initial begin
      rst     = 1'b1;
      adc_raw = 12'h000;
      repeat (10) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      `CHK({reg_rdata, conv_done_n, chan_sel}, {16'h0000, 1'b1, 3'h0})
      host.rd(AAAS_A_STAT, v);
      `CHK(v, 16'h8000)
      host.rd(AAAS_A_CTRL, v);
      `CHK(v, 16'h4000)
      host.set_cfg();
      foreach (rows[i]) begin
         r = rows[i];
         adc_raw = r.raw;
         w = {2'b00, r.scan, r.res, r.avg, r.clk, 3'b000, r.filt};
         base = r.n * (r.bits + AAAS_CONV_EXTRA) * AAAS_DIV_CYC[r.clk];
         run_set(w, base, r.ch);
         `CHK(cnt >= base - 4 && cnt <= base + r.n + 12, 1'b1)
         `CHK(conv_done_n, 1'b0)
         host.rd(AAAS_A_STAT, v);
         `CHK(v, 16'h4800 | (16'h0001 << AAAS_FLAG_BIT[r.ch]))
         host.rd(AAAS_A_CTRL, v);
         `CHK(v & 16'hBFFF, w)
         host.rd(4'(AAAS_A_RES0 + r.ch), v);
         `CHK(v, {4'h0, r.raw})
         repeat (2) @(posedge sys_clk);
         #1;
         `CHK(conv_done_n, 1'b1)
         host.rd(AAAS_A_STAT, v);
         `CHK(v, 16'h4000)
      end
      // port scan, three results read back highest address first
      adc_raw = 12'h0F0;
      run_set({2'b00, AAAS_SCAN_PORT, 2'b01, 2'b00, 2'b00, 4'h0}, 576, 0);
      `CHK(cnt >= 572 && cnt <= 600, 1'b1)
      host.rd(AAAS_A_STAT, v);
      `CHK(v, 16'h4870)
      for (int c = 2; c >= 0; c--) begin
         `CHK(conv_done_n, 1'b0)
         host.rd(4'(AAAS_A_RES0 + c), v);
         `CHK(v, 16'h00F0)
      end
      repeat (2) @(posedge sys_clk);
      #1;
      `CHK(conv_done_n, 1'b1)
      // stop with every bit set: reserved bits dropped, halted shown
      host.wr(AAAS_A_CTRL, 16'hFFFF);
      host.rd(AAAS_A_CTRL, v);
      `CHK(v, 16'h7FF1)
      host.rd(AAAS_A_STAT, v);
      `CHK(v, 16'h6000)
      host.rd(4'h2, v);
      `CHK(v, 16'h0000)
      host.wr(AAAS_A_STAT, 16'hFFFF);
      host.rd(AAAS_A_STAT, v);
      `CHK(v, 16'hE000)
      // reserved pin code: set completes, pin stays high
      run_set(16'h1900, 192, 0);
      `CHK(conv_done_n, 1'b1)
      host.rd(AAAS_A_STAT, v);
      `CHK(v, 16'hC840)
      // reset with a result pending: outputs and status back to idle values
      rst = 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      `CHK({reg_rdata, conv_done_n, chan_sel}, {16'h0000, 1'b1, 3'h0})
      host.rd(AAAS_A_STAT, v);
      `CHK(v, 16'h8000)
      end_sim;
   end
endmodule
